// ### hw/ftc_port.sv
/*
  Coprocessor transfer, conversion and condition port. Holds the register
  file and the condition bit, moves words and doublewords to and from
  memory and the integer core, range-checks long fixed conversions and
  resolves compare and branch. Assumes the integer core issues one op per
  cycle while stall_out is low and shares clk_in and srst_in.
*/
`timescale 1ns/1ps
module ftc_port
#(
  parameter int REGS = ftc_pkg::FTC_REG_COUNT
)
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // Issue from integer core
  input  wire logic                  issue_valid_in,
  input  wire ftc_pkg::ftc_op_t      issue_op_in,
  input  wire ftc_pkg::ftc_fmt_t     issue_fmt_in,
  input  wire logic [4:0]            fs_in,
  input  wire logic [4:0]            ft_in,
  input  wire logic [4:0]            fd_in,
  input  wire logic [3:0]            pred_in,
  input  wire logic [63:0]           addr_in,
  input  wire logic [63:0]           core_data_in,
  input  wire logic                  big_endian_in,
  // Memory side
  input  wire logic                  mem_rvalid_in,
  input  wire logic [63:0]           mem_rdata_in,
  output logic                       mem_req_out,
  output logic                       mem_we_out,
  output logic                       mem_dword_out,
  output logic [63:0]                mem_addr_out,
  output logic [63:0]                mem_wdata_out,
  output logic [7:0]                 mem_be_out,
  // Results to integer core
  output logic                       stall_out,
  output logic                       done_out,
  output logic [63:0]                core_data_out,
  output logic                       branch_taken_out,
  output logic                       branch_nullify_out,
  output logic                       fp_exc_out,
  output logic                       addr_err_out
);
  import ftc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum {FTC_IDLE, FTC_LOAD_WAIT} ftc_state_t;

  ftc_state_t   state;
  ftc_state_t   next_state;
  logic [63:0]  regs [REGS];
  logic [31:0]  csr;
  logic [31:0]  next_csr;
  logic [4:0]   load_dst;
  logic [4:0]   next_load_dst;
  logic         load_dword;
  logic         next_load_dword;
  logic         wr_en;
  logic [4:0]   wr_idx;
  logic [63:0]  wr_val;

  logic         next_mem_req;
  logic         next_mem_we;
  logic         next_mem_dword;
  logic [63:0]  next_mem_addr;
  logic [63:0]  next_mem_wdata;
  logic [7:0]   next_mem_be;
  logic         next_stall;
  logic         next_done;
  logic [63:0]  next_core_data;
  logic         next_taken;
  logic         next_nullify;
  logic         next_fp_exc;
  logic         next_addr_err;

  logic [63:0]  conv_result;
  logic         conv_oor;
  logic         cmp_cond;
  logic         cmp_invalid;
  logic         misalign;
  logic         hazard;

  // ----------------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------------
  ftc_long_range u_range
  (
    .src_in           (regs[fs_in]),
    .fmt_in           (issue_fmt_in),
    .op_in            (issue_op_in),
    .round_mode_in    (csr[1:0]),
    .result_out       (conv_result),
    .out_of_range_out (conv_oor)
  );

  ftc_compare u_cmp
  (
    .a_in        (regs[fs_in]),
    .b_in        (regs[ft_in]),
    .fmt_in      (issue_fmt_in),
    .pred_in     (pred_in),
    .cond_out    (cmp_cond),
    .invalid_out (cmp_invalid)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_csr        = csr;
    next_load_dst   = load_dst;
    next_load_dword = load_dword;
    wr_en           = 1'b0;
    wr_idx          = fd_in;
    wr_val          = 64'h0;
    next_mem_req    = 1'b0;
    next_mem_we     = 1'b0;
    next_mem_dword  = 1'b0;
    next_mem_addr   = mem_addr_out;
    next_mem_wdata  = mem_wdata_out;
    next_mem_be     = 8'h00;
    next_stall      = 1'b0;
    next_done       = 1'b0;
    next_core_data  = core_data_out;
    next_taken      = 1'b0;
    next_nullify    = 1'b0;
    next_fp_exc     = 1'b0;
    next_addr_err   = 1'b0;
    // Alignment by access size
    unique case (issue_op_in)
      FTC_OP_LOAD_WORD, FTC_OP_STORE_WORD:
        misalign = |addr_in[FTC_WORD_ALIGN_W-1:0];
      FTC_OP_LOAD_DWORD, FTC_OP_STORE_DWORD:
        misalign = |addr_in[FTC_DWORD_ALIGN_W-1:0];
      default:
        misalign = 1'b0;
    endcase
    // Reader of a register still loading waits
    hazard = (state == FTC_LOAD_WAIT) && issue_valid_in
           && (fs_in == load_dst || ft_in == load_dst);
    unique case (state)
      FTC_IDLE:
      begin
        if (issue_valid_in)
        begin
          next_done = 1'b1;
          unique case (issue_op_in) // decoded op word
            FTC_OP_LOAD_WORD, FTC_OP_LOAD_DWORD,
            FTC_OP_STORE_WORD, FTC_OP_STORE_DWORD:
            begin
              if (misalign)
                next_addr_err = 1'b1;
              else
              begin
                next_mem_req   = 1'b1;
                next_mem_addr  = addr_in; // lowest byte address
                next_mem_dword = issue_op_in inside {FTC_OP_LOAD_DWORD,
                                                     FTC_OP_STORE_DWORD};
                // Word lane: lower address half holds the leftmost byte
                // when big-endian
                if (next_mem_dword)
                  next_mem_be = 8'hFF;
                else if (addr_in[2] ^ big_endian_in)
                  next_mem_be = 8'hF0;
                else
                  next_mem_be = 8'h0F;
                if (issue_op_in == FTC_OP_STORE_WORD)
                begin
                  next_mem_we    = 1'b1;
                  next_mem_wdata = {regs[ft_in][31:0], regs[ft_in][31:0]};
                end
                else if (issue_op_in == FTC_OP_STORE_DWORD)
                begin
                  next_mem_we    = 1'b1;
                  next_mem_wdata = regs[ft_in]; // raw bits
                end
                else
                begin
                  next_done       = 1'b0;
                  next_stall      = 1'b1;
                  next_state      = FTC_LOAD_WAIT;
                  next_load_dst   = ft_in;
                  next_load_dword = next_mem_dword;
                end
              end
            end
            FTC_OP_MOVE_WORD_TO:
            begin
              wr_en  = 1'b1;
              wr_idx = fs_in;
              wr_val = {regs[fs_in][63:32], core_data_in[31:0]};
            end
            FTC_OP_MOVE_DWORD_TO:
            begin
              wr_en  = 1'b1;
              wr_idx = fs_in;
              wr_val = core_data_in;
            end
            FTC_OP_MOVE_WORD_FROM:
              next_core_data = {{32{regs[fs_in][31]}}, regs[fs_in][31:0]};
            FTC_OP_MOVE_DWORD_FROM:
              next_core_data = regs[fs_in];
            FTC_OP_MOVE_CTRL_TO:
              next_csr = core_data_in[31:0];
            FTC_OP_MOVE_CTRL_FROM:
              next_core_data = {32'h0, csr};
            FTC_OP_CEILING_TO_LONG_FIXED, FTC_OP_CONVERT_TO_LONG_FIXED, FTC_OP_FLOOR_L,
            FTC_OP_ROUND_L, FTC_OP_TRUNCATE_TO_LONG_FIXED:
            begin
              // Sources are S or D only
              if (issue_fmt_in == FTC_FMT_SINGLE ||
                  issue_fmt_in == FTC_FMT_DOUBLE)
              begin
                next_csr[FTC_CSR_E_BIT] = conv_oor;
                if (conv_oor)
                  next_fp_exc = 1'b1; // no enable gate
                else
                begin
                  wr_en  = 1'b1;
                  wr_val = conv_result;
                end
              end
              else
              begin
                next_csr[FTC_CSR_E_BIT] = 1'b1;
                next_fp_exc = 1'b1;
              end
            end
            FTC_OP_COMPARE:
            begin
              // Fixed formats are not valid compare formats
              if (issue_fmt_in == FTC_FMT_SINGLE ||
                  issue_fmt_in == FTC_FMT_DOUBLE)
                next_csr[FTC_CSR_COND_BIT] = cmp_cond;
              next_fp_exc = cmp_invalid & csr[11];
            end
            FTC_OP_BRANCH_TRUE, FTC_OP_BRANCH_TRUE_LIKELY:
            begin
              next_taken   = csr[FTC_CSR_COND_BIT];
              next_nullify = !csr[FTC_CSR_COND_BIT]
                           && issue_op_in == FTC_OP_BRANCH_TRUE_LIKELY;
            end
            FTC_OP_BRANCH_FALSE, FTC_OP_BRANCH_FALSE_LIKELY:
            begin
              next_taken   = !csr[FTC_CSR_COND_BIT];
              next_nullify = csr[FTC_CSR_COND_BIT]
                           && issue_op_in == FTC_OP_BRANCH_FALSE_LIKELY;
            end
            default:
              next_done = 1'b0;
          endcase
        end
      end
      FTC_LOAD_WAIT:
      begin
        next_stall = !mem_rvalid_in || hazard;
        if (mem_rvalid_in)
        begin
          wr_en      = 1'b1;
          wr_idx     = load_dst;
          next_done  = 1'b1;
          next_state = FTC_IDLE;
          if (load_dword)
            wr_val = mem_rdata_in; // unchanged bits
          else
            wr_val = {regs[load_dst][63:32],
                      (mem_addr_out[2] ^ big_endian_in)
                        ? mem_rdata_in[63:32] : mem_rdata_in[31:0]};
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state              <= FTC_IDLE;
      csr                <= FTC_CSR_RESET;
      load_dst           <= 5'h00;
      load_dword         <= 1'b0;
      mem_req_out        <= 1'b0;
      mem_we_out         <= 1'b0;
      mem_dword_out      <= 1'b0;
      mem_addr_out       <= 64'h0;
      mem_wdata_out      <= 64'h0;
      mem_be_out         <= 8'h00;
      stall_out          <= 1'b0;
      done_out           <= 1'b0;
      core_data_out      <= 64'h0;
      branch_taken_out   <= 1'b0;
      branch_nullify_out <= 1'b0;
      fp_exc_out         <= 1'b0;
      addr_err_out       <= 1'b0;
      for (int i = 0; i < REGS; i++)
        regs[i] <= FTC_REG_RESET;
    end
    else
    begin
      state              <= next_state;
      csr                <= next_csr;
      load_dst           <= next_load_dst;
      load_dword         <= next_load_dword;
      mem_req_out        <= next_mem_req;
      mem_we_out         <= next_mem_we;
      mem_dword_out      <= next_mem_dword;
      mem_addr_out       <= next_mem_addr;
      mem_wdata_out      <= next_mem_wdata;
      mem_be_out         <= next_mem_be;
      stall_out          <= next_stall;
      done_out           <= next_done;
      core_data_out      <= next_core_data;
      branch_taken_out   <= next_taken;
      branch_nullify_out <= next_nullify;
      fp_exc_out         <= next_fp_exc;
      addr_err_out       <= next_addr_err;
      if (wr_en)
        regs[wr_idx] <= wr_val;
    end
  end
endmodule

// ### hw/ftc_pkg.sv
/*
  Shared constants and types for the floating-point transfer, convert and
  check port. Assumes one clock and one synchronous reset shared with the
  integer core that issues the coprocessor operations.
*/
package ftc_pkg;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    FTC_OP_NONE,
    FTC_OP_LOAD_WORD,
    FTC_OP_LOAD_DWORD,
    FTC_OP_STORE_WORD,
    FTC_OP_STORE_DWORD,
    FTC_OP_MOVE_WORD_TO,
    FTC_OP_MOVE_WORD_FROM,
    FTC_OP_MOVE_DWORD_TO,
    FTC_OP_MOVE_DWORD_FROM,
    FTC_OP_MOVE_CTRL_TO,
    FTC_OP_MOVE_CTRL_FROM,
    FTC_OP_CEILING_TO_LONG_FIXED,
    FTC_OP_CONVERT_TO_LONG_FIXED,
    FTC_OP_FLOOR_L,
    FTC_OP_ROUND_L,
    FTC_OP_TRUNCATE_TO_LONG_FIXED,
    FTC_OP_COMPARE,
    FTC_OP_BRANCH_TRUE,
    FTC_OP_BRANCH_FALSE,
    FTC_OP_BRANCH_TRUE_LIKELY,
    FTC_OP_BRANCH_FALSE_LIKELY
  } ftc_op_t;

  // ----------------------------------------------------------------------
  // Format codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FTC_FMT_SINGLE,
    FTC_FMT_DOUBLE,
    FTC_FMT_WORD_FIXED,
    FTC_FMT_LONG_FIXED
  } ftc_fmt_t;

  // ----------------------------------------------------------------------
  // Widths, positions and reset values
  // ----------------------------------------------------------------------
  localparam int          FTC_INSTR_W      = 32;
  localparam int          FTC_REG_COUNT    = 32;
  localparam int          FTC_CSR_COND_BIT = 23;
  localparam int          FTC_CSR_E_BIT    = 17;
  localparam int          FTC_WORD_ALIGN_W = 2;
  localparam int          FTC_DWORD_ALIGN_W = 3;
  localparam int          FTC_LONG_LIMIT_EXP = 52;
  localparam logic [31:0] FTC_CSR_RESET    = 32'h0000_0000;
  localparam logic [63:0] FTC_REG_RESET    = 64'h0000_0000_0000_0000;
  localparam int          FTC_LOAD_STALL_CYCLES = 1;

  // Compare predicate bits: unordered, equal, less, signaling
  localparam int FTC_PRED_UN_BIT = 0;
  localparam int FTC_PRED_EQ_BIT = 1;
  localparam int FTC_PRED_LT_BIT = 2;

endpackage

// ### hw/ftc_long_range.sv
/*
  Floating-point to 64-bit fixed conversion with range check.
  Assumes a combinational use inside the port's single clock domain.
*/
`timescale 1ns/1ps
module ftc_long_range
(
  // Operand
  input  wire logic [63:0]       src_in,
  input  wire ftc_pkg::ftc_fmt_t fmt_in,
  input  wire ftc_pkg::ftc_op_t  op_in,
  input  wire logic [1:0]        round_mode_in,
  // Result
  output logic      [63:0]       result_out,
  output logic                   out_of_range_out
);
  import ftc_pkg::*;

  logic        sign;
  logic [10:0] exp_b;
  logic [52:0] mant;
  logic [116:0] wide;
  logic [63:0] mag;
  logic        frac_nz;
  logic        half;
  logic        rest;
  logic        up;
  logic        special;

  always_comb
  begin
    sign    = 1'b0;
    exp_b   = 11'h000;
    mant    = 53'h0;
    special = 1'b0;
    if (fmt_in == FTC_FMT_SINGLE)
    begin
      sign    = src_in[31];
      exp_b   = {3'h0, src_in[30:23]} + 11'h380;
      mant    = {1'b1, src_in[22:0], 29'h0};
      special = (src_in[30:23] == 8'hFF);
      if (src_in[30:23] == 8'h00)
        mant[52] = 1'b0;
    end
    else
    begin
      sign    = src_in[63];
      exp_b   = src_in[62:52];
      mant    = {1'b1, src_in[51:0]};
      special = (src_in[62:52] == 11'h7FF);
      if (src_in[62:52] == 11'h000)
        mant[52] = 1'b0;
    end
    // Integer part lands in wide[116:53], fraction below; values under
    // one half keep only a sticky bit
    if (exp_b < 11'd1022)
      wide = {116'h0, |mant};
    else if (exp_b < 11'd1086)
      wide = 117'(mant) << (exp_b - 11'd1022);
    else
      wide = {117{1'b1}};
    mag     = wide[116:53];
    half    = wide[52];
    rest    = |wide[51:0];
    frac_nz = half | rest;
    unique case (op_in)
      FTC_OP_TRUNCATE_TO_LONG_FIXED: up = 1'b0;
      FTC_OP_CEILING_TO_LONG_FIXED:  up = frac_nz & ~sign;
      FTC_OP_FLOOR_L: up = frac_nz & sign;
      FTC_OP_ROUND_L: up = half & (rest | mag[0]);
      default:
        unique case (round_mode_in)
          2'd0:    up = half & (rest | mag[0]);
          2'd1:    up = 1'b0;
          2'd2:    up = frac_nz & ~sign;
          default: up = frac_nz & sign;
        endcase
    endcase
    mag = mag + {63'h0, up};
    if (exp_b >= 11'd1086)
      mag = 64'hFFFF_FFFF_FFFF_FFFF;
    // Signed range -2^52 .. 2^52-1
    out_of_range_out = special
      || (|mag[63:FTC_LONG_LIMIT_EXP+1])
      || (mag[FTC_LONG_LIMIT_EXP] && !(sign && mag[51:0] == 52'h0));
    // Two's-complement result
    result_out = sign ? (~mag + 64'h1) : mag;
  end
endmodule

// ### hw/ftc_compare.sv
/*
  Floating-point compare against an encoded predicate.
  Assumes combinational use inside the port's single clock domain.
*/
`timescale 1ns/1ps
module ftc_compare
(
  // Operands
  input  wire logic [63:0]       a_in,
  input  wire logic [63:0]       b_in,
  input  wire ftc_pkg::ftc_fmt_t fmt_in,
  input  wire logic [3:0]        pred_in,
  // Result
  output logic                   cond_out,
  output logic                   invalid_out
);
  import ftc_pkg::*;

  logic        sa;
  logic        sb;
  logic [62:0] ma;
  logic [62:0] mb;
  logic        nan_a;
  logic        nan_b;
  logic        unord;
  logic        eq;
  logic        lt;

  always_comb
  begin
    if (fmt_in == FTC_FMT_SINGLE)
    begin
      sa    = a_in[31];
      sb    = b_in[31];
      ma    = {32'h0, a_in[30:0]};
      mb    = {32'h0, b_in[30:0]};
      nan_a = (a_in[30:23] == 8'hFF) && (a_in[22:0] != 23'h0);
      nan_b = (b_in[30:23] == 8'hFF) && (b_in[22:0] != 23'h0);
    end
    else
    begin
      sa    = a_in[63];
      sb    = b_in[63];
      ma    = a_in[62:0];
      mb    = b_in[62:0];
      nan_a = (a_in[62:52] == 11'h7FF) && (a_in[51:0] != 52'h0);
      nan_b = (b_in[62:52] == 11'h7FF) && (b_in[51:0] != 52'h0);
    end
    unord = nan_a | nan_b;
    eq    = !unord && ((ma == mb && sa == sb) || (ma == 63'h0 && mb == 63'h0));
    if (unord || eq)
      lt = 1'b0;
    else if (sa != sb)
      lt = sa;
    else
      lt = sa ? (ma > mb) : (ma < mb);
    // Arithmetic relation against predicate
    cond_out = (pred_in[FTC_PRED_UN_BIT] & unord)
             | (pred_in[FTC_PRED_EQ_BIT] & eq)
             | (pred_in[FTC_PRED_LT_BIT] & lt);
    invalid_out = pred_in[3] & unord;
  end
endmodule

// ### test/ftc_port_chk.sv
/*
  Pin-level checks on ftc_port.
  Assumes one clock and the synchronous reset shared with the core.
*/
`timescale 1ns/1ps
module ftc_port_chk
(
  // Watched pins
  input wire logic              clk_in,
  input wire logic              srst_in,
  input wire logic              issue_valid_in,
  input wire ftc_pkg::ftc_op_t  issue_op_in,
  input wire logic [63:0]       addr_in,
  input wire logic              big_endian_in,
  input wire logic              mem_rvalid_in,
  input wire logic              mem_req_out,
  input wire logic              mem_we_out,
  input wire logic              mem_dword_out,
  input wire logic [63:0]       mem_addr_out,
  input wire logic [7:0]        mem_be_out,
  input wire logic              stall_out,
  input wire logic              done_out,
  input wire logic              fp_exc_out,
  input wire logic              addr_err_out,
  input wire logic              branch_taken_out
);
  import ftc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic idle;
  // No load in flight, so an issue would be taken
  assign idle = !stall_out && !(mem_req_out && !mem_we_out);
  a_dword_lanes: assert property (
    mem_req_out && mem_dword_out |-> mem_be_out == 8'hFF)
    else $error("dword strobes not all set");
  a_word_lane: assert property (
    mem_req_out && !mem_dword_out |-> mem_be_out ==
    ((mem_addr_out[2] ^ big_endian_in) ? 8'hF0 : 8'h0F))
    else $error("word strobes on wrong lane");
  a_word_aligned: assert property (
    mem_req_out && !mem_dword_out |-> mem_addr_out[1:0] == 2'h0)
    else $error("misaligned word request");
  a_dword_aligned: assert property (
    mem_req_out && mem_dword_out |-> mem_addr_out[2:0] == 3'h0)
    else $error("misaligned dword request");
  a_misalign_err: assert property (
    issue_valid_in && idle && issue_op_in == FTC_OP_LOAD_DWORD &&
    addr_in[2:0] != 3'h0 |=> addr_err_out && !mem_req_out)
    else $error("misaligned load not refused");
  a_move_no_exc: assert property (
    issue_valid_in && idle && issue_op_in inside {FTC_OP_MOVE_WORD_TO,
    FTC_OP_MOVE_WORD_FROM, FTC_OP_MOVE_DWORD_TO, FTC_OP_MOVE_DWORD_FROM}
    |=> done_out && !fp_exc_out)
    else $error("move not clean in one cycle");
  a_load_stall: assert property (
    mem_req_out && !mem_we_out && !mem_rvalid_in |=> stall_out)
    else $error("no stall while load waits");
  a_load_done: assert property (
    stall_out && mem_rvalid_in |=> done_out && !stall_out && !fp_exc_out)
    else $error("load return not completed cleanly");
  a_branch_cause: assert property (
    branch_taken_out |-> $past(issue_valid_in) &&
    $past(issue_op_in) inside {FTC_OP_BRANCH_TRUE, FTC_OP_BRANCH_FALSE,
    FTC_OP_BRANCH_TRUE_LIKELY, FTC_OP_BRANCH_FALSE_LIKELY})
    else $error("branch taken without branch issue");
endmodule
bind ftc_port ftc_port_chk u_chk (.*);

// ### test/ftc_mem_model.sv
/*
  Memory behind the port's load/store pins.
  Assumes aligned 64-bit lanes and a load delay chosen by the bench.
*/
`timescale 1ns/1ps
module ftc_mem_model
(
  // Requests from the port
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [63:0] addr_in,
  input  wire logic [63:0] wdata_in,
  input  wire logic [7:0]  be_in,
  input  wire logic [3:0]  delay_in,
  // Load return
  output logic             rvalid_out,
  output logic [63:0]      rdata_out
);
  logic [63:0] mem [16];
  logic [63:0] held;
  int          cnt;
  always @(posedge clk_in)
  begin
    rvalid_out <= 1'b0;
    rdata_out  <= ~rdata_out;
    if (srst_in)
    begin
      cnt       <= 0;
      rdata_out <= 64'h5A5A_0F0F_A5A5_F0F0;
    end
    else if (req_in && we_in)
    begin
      for (int i = 0; i < 8; i++)
        if (be_in[i])
          mem[addr_in[6:3]][8*i +: 8] <= wdata_in[8*i +: 8];
    end
    else if (req_in)
    begin
      held <= mem[addr_in[6:3]];
      cnt  <= delay_in + 1;
    end
    else if (cnt == 1)
    begin
      rvalid_out <= 1'b1;
      rdata_out  <= held;
      cnt        <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// ### test/tb_top.sv
/*
  Bench for ftc_port, acting as the issuing core.
  Assumes ftc_mem_model answers loads and the checker is bound.
*/
`timescale 1ns/1ps
module tb_top;
  import ftc_pkg::*;
  logic        clk_in = 0, srst_in = 1, issue_valid_in = 0;
  logic        big_endian_in = 0, mem_rvalid_in, mem_req_out;
  logic        mem_we_out, mem_dword_out, stall_out, done_out;
  logic        branch_taken_out, branch_nullify_out;
  logic        fp_exc_out, addr_err_out, r_req, r_exc, r_err, r_tk, r_nul;
  ftc_op_t     issue_op_in = FTC_OP_NONE;
  ftc_fmt_t    issue_fmt_in = FTC_FMT_DOUBLE;
  logic [4:0]  fs_in = 0, ft_in = 0, fd_in = 0;
  logic [3:0]  pred_in = 0, dly = 0;
  logic [7:0]  mem_be_out, r_be;
  logic [63:0] addr_in = 0, core_data_in = 0, mem_rdata_in, mem_addr_out;
  logic [63:0] mem_wdata_out, core_data_out;
  int          n_fail = 0, checked = 0;
  always #2 clk_in = ~clk_in;
  ftc_port DUT (.*);
  ftc_mem_model MEM (.clk_in(clk_in), .srst_in(srst_in),
    .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .be_in(mem_be_out), .delay_in(dly),
    .rvalid_out(mem_rvalid_in), .rdata_out(mem_rdata_in));
  task automatic test_done();
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic iss(input ftc_op_t o, input ftc_fmt_t f,
                     input logic [4:0] s, t, d, input logic [63:0] a, v);
    int i;
    issue_valid_in = 1'b1;
    issue_op_in    = o;
    issue_fmt_in   = f;
    fs_in          = s;
    ft_in          = t;
    fd_in          = d;
    addr_in        = a;
    core_data_in   = v;
    @(posedge clk_in);
    #1;
    issue_valid_in = 1'b0;
    r_req          = mem_req_out;
    r_be           = mem_be_out;
    i              = 0;
    while (done_out !== 1'b1 && addr_err_out !== 1'b1 && i < 40)
    begin
      @(posedge clk_in);
      #1;
      i++;
    end
    if (i == 40)
    begin
      n_fail++;
      test_done();
    end
    r_exc = fp_exc_out;
    r_err = addr_err_out;
    r_tk  = branch_taken_out;
    r_nul = branch_nullify_out;
    @(posedge clk_in);
    #1;
  endtask
  task automatic mv(input logic [4:0] r, input logic [63:0] v);
    iss(FTC_OP_MOVE_DWORD_TO, FTC_FMT_DOUBLE, r, 0, 0, 0, v);
  endtask
  task automatic rd(input logic [4:0] r, input logic [63:0] e);
    iss(FTC_OP_MOVE_DWORD_FROM, FTC_FMT_DOUBLE, r, 0, 0, 0, 0);
    chk("reg value", e, core_data_out);
  endtask
  task automatic t_move();
    mv(5'd1, 64'h8123_4567_89AB_CDEF);
    chb("move exc", 1'b0, r_exc);
    rd(5'd1, 64'h8123_4567_89AB_CDEF);
    iss(FTC_OP_MOVE_WORD_TO, FTC_FMT_SINGLE, 1, 0, 0, 0, 64'hFEDC_BA98);
    iss(FTC_OP_MOVE_WORD_FROM, FTC_FMT_SINGLE, 1, 0, 0, 0, 0);
    chk("word sext", 64'hFFFF_FFFF_FEDC_BA98, core_data_out);
    rd(5'd1, 64'h8123_4567_FEDC_BA98);
    $display("t_move done");
  endtask
  task automatic t_mem();
    dly = 4'd3;
    iss(FTC_OP_STORE_DWORD, FTC_FMT_DOUBLE, 0, 1, 0, 64'h10, 0);
    chk("dword be", 64'hFF, {56'h0, r_be});
    iss(FTC_OP_LOAD_DWORD, FTC_FMT_DOUBLE, 0, 2, 0, 64'h10, 0);
    rd(5'd2, 64'h8123_4567_FEDC_BA98);
    for (int e = 0; e < 2; e++)
    begin
      big_endian_in = e[0];
      dly           = e[0] ? 4'd0 : 4'd6;
      iss(FTC_OP_STORE_WORD, FTC_FMT_SINGLE, 0, 1, 0, 64'h24, 0);
      chk("word be", e[0] ? 64'h0F : 64'hF0, {56'h0, r_be});
      iss(FTC_OP_LOAD_WORD, FTC_FMT_SINGLE, 0, 3, 0, 64'h24, 0);
      iss(FTC_OP_MOVE_WORD_FROM, FTC_FMT_SINGLE, 3, 0, 0, 0, 0);
      chk("word load", 64'hFFFF_FFFF_FEDC_BA98, core_data_out);
    end
    $display("t_mem done");
  endtask
  task automatic t_align();
    iss(FTC_OP_LOAD_WORD, FTC_FMT_SINGLE, 0, 1, 0, 64'h22, 0);
    chb("word misalign", 1'b1, r_err);
    chb("no request", 1'b0, r_req);
    iss(FTC_OP_LOAD_DWORD, FTC_FMT_DOUBLE, 0, 1, 0, 64'h14, 0);
    chb("dword misalign", 1'b1, r_err);
    iss(FTC_OP_STORE_DWORD, FTC_FMT_DOUBLE, 0, 3, 0, 64'h12, 0);
    chb("store misalign", 1'b1, r_err);
    rd(5'd1, 64'h8123_4567_FEDC_BA98);
    iss(FTC_OP_LOAD_DWORD, FTC_FMT_DOUBLE, 0, 2, 0, 64'h10, 0);
    rd(5'd2, 64'h8123_4567_FEDC_BA98);
    $display("t_align done");
  endtask
  task automatic cv(input ftc_op_t o, input ftc_fmt_t f, input logic [4:0] s,
                    input logic x, input logic [63:0] v);
    iss(o, f, s, 0, 5'd6, 0, 0);
    chb("conv exc", x, r_exc);
    rd(5'd6, v);
  endtask
  task automatic t_conv();
    ftc_op_t o;
    mv(5'd4, 64'h3FF0_0000_0000_0000);
    mv(5'd5, 64'h4340_0000_0000_0000);
    mv(5'd7, 64'hC330_0000_0000_0000);
    iss(FTC_OP_MOVE_WORD_TO, FTC_FMT_SINGLE, 8, 0, 0, 0, 64'h3F80_0000);
    iss(FTC_OP_MOVE_WORD_TO, FTC_FMT_SINGLE, 9, 0, 0, 0, 64'h5A00_0000);
    for (int k = 0; k < 5; k++)
    begin
      o = ftc_op_t'(int'(FTC_OP_CEILING_TO_LONG_FIXED) + k);
      cv(o, FTC_FMT_DOUBLE, 5'd4, 1'b0, 64'h1);
      cv(o, FTC_FMT_DOUBLE, 5'd5, 1'b1, 64'h1);
      cv(o, FTC_FMT_SINGLE, 5'd8, 1'b0, 64'h1);
      cv(o, FTC_FMT_SINGLE, 5'd9, 1'b1, 64'h1);
    end
    cv(FTC_OP_CONVERT_TO_LONG_FIXED, FTC_FMT_DOUBLE, 7, 0, {12'hFFF, 52'h0});
    iss(FTC_OP_MOVE_CTRL_TO, FTC_FMT_SINGLE, 0, 0, 0, 0, 64'h1);
    mv(5'd10, 64'hBFF8_0000_0000_0000);
    cv(FTC_OP_CONVERT_TO_LONG_FIXED, FTC_FMT_DOUBLE, 10, 0, {64{1'b1}});
    cv(FTC_OP_CONVERT_TO_LONG_FIXED, FTC_FMT_LONG_FIXED, 4, 1, {64{1'b1}});
    iss(FTC_OP_MOVE_CTRL_FROM, FTC_FMT_SINGLE, 0, 0, 0, 0, 0);
    chk("control word", 64'h2_0001, core_data_out);
    $display("t_conv done");
  endtask
  task automatic br(input ftc_op_t o, input logic tk, nul);
    iss(o, FTC_FMT_DOUBLE, 0, 0, 0, 0, 0);
    chb("taken", tk, r_tk);
    chb("nullify", nul, r_nul);
  endtask
  task automatic t_cmp();
    pred_in = 4'h2;
    iss(FTC_OP_COMPARE, FTC_FMT_DOUBLE, 4, 4, 0, 0, 0);
    br(FTC_OP_BRANCH_TRUE, 1'b1, 1'b0);
    br(FTC_OP_BRANCH_FALSE, 1'b0, 1'b0);
    br(FTC_OP_BRANCH_FALSE_LIKELY, 1'b0, 1'b1);
    br(FTC_OP_BRANCH_TRUE_LIKELY, 1'b1, 1'b0);
    pred_in = 4'h4;
    iss(FTC_OP_COMPARE, FTC_FMT_DOUBLE, 5, 4, 0, 0, 0);
    br(FTC_OP_BRANCH_TRUE, 1'b0, 1'b0);
    br(FTC_OP_BRANCH_TRUE_LIKELY, 1'b0, 1'b1);
    pred_in = 4'h2;
    iss(FTC_OP_COMPARE, FTC_FMT_WORD_FIXED, 4, 4, 0, 0, 0);
    br(FTC_OP_BRANCH_FALSE, 1'b1, 1'b0);
    $display("t_cmp done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    t_move();
    t_mem();
    t_align();
    t_conv();
    t_cmp();
    test_done();
  end
endmodule
